// ---- core/dtc_pkg.sv ----
// Constants for the dual timer/counter special-function-register block
// Behaviour
// - Registers live at 80h-FFh, direct addressing only
// - Bit access only where address ends 0/8
// - Unimplemented locations and bits read as one
// - Overflow sets flag; vector clears; software writes
// - Run bit enables its timer/counter, except that with timer 0 split TR1 runs the high half of timer 0
// - Detect flag: edge cleared on vector, level tracks
// - Type bit selects edge or level trigger
// - Gating: count only while interrupt pin high
// - Select bit: internal clock or count-pin falling edges
// - Mode 0: 8-bit counter, 5-bit prescaler
// - Mode 1: full 16-bit counter
// - Mode 2: low byte auto-reloads from high
// - Mode 3 splits timer 0 in two
// - Timer 1 in mode 3 holds
// - Mode register: upper nibble timer 1
// - Watchdog select picks period; reset 512 later
// - Clock select: divide by 4 or 12
// - Idle stops core clock, timers keep running
// - Power-down freezes timers
package dtc_pkg;
   localparam logic [7:0] SFR_BASE = 8'h80;
   localparam logic [7:0] ADDR_TCTL = 8'h88;
   localparam logic [7:0] ADDR_TMODE = 8'h89;
   localparam logic [7:0] ADDR_T0LO = 8'h8A;
   localparam logic [7:0] ADDR_T1LO = 8'h8B;
   localparam logic [7:0] ADDR_T0HI = 8'h8C;
   localparam logic [7:0] ADDR_T1HI = 8'h8D;
   localparam logic [7:0] ADDR_CKCTL = 8'h8E;
   localparam logic [7:0] UNIMPL_READ = 8'hFF;
   localparam logic [6:0] UNIMPL_BITS = 7'h7F;
   // Control register bit positions
   localparam int TC_TF1 = 7;
   localparam int TC_TR1 = 6;
   localparam int TC_TF0 = 5;
   localparam int TC_TR0 = 4;
   localparam int TC_IE1 = 3;
   localparam int TC_IT1 = 2;
   localparam int TC_IE0 = 1;
   localparam int TC_IT0 = 0;
   // Mode register: nibble base per timer, then fields within a nibble
   localparam int TM_T0_LSB = 0;
   localparam int TM_T1_LSB = 4;
   localparam int TM_GATE = 3;
   localparam int TM_CT = 2;
   localparam logic [1:0] MODE_PRESCALED = 2'h0;
   localparam logic [1:0] MODE_FULL16 = 2'h1;
   localparam logic [1:0] MODE_RELOAD8 = 2'h2;
   localparam logic [1:0] MODE_SPLIT = 2'h3;
   // Clock control fields
   localparam int CK_WD_LSB = 6;
   localparam int CK_T1M = 4;
   localparam int CK_T0M = 3;
   localparam logic [7:0] RST_TCTL = 8'h00;
   localparam logic [7:0] RST_TMODE = 8'h00;
   localparam logic [7:0] RST_COUNT = 8'h00;
   localparam logic [7:0] RST_CKCTL = 8'h01;
   localparam logic [3:0] RST_DIV = 4'h0;
   localparam logic [3:0] RST_PINS = 4'hF;
   localparam logic [7:0] RST_RDATA = 8'h00;
   localparam logic [26:0] RST_WD_IRQ = 27'h0020000;
   localparam logic [26:0] RST_WD_RST = 27'h0020200;
   // Timing
   localparam int DIV_FAST = 4;
   localparam int DIV_SLOW = 12;
   localparam logic [4:0] WD_EXP0 = 5'h11;
   localparam logic [4:0] WD_EXP_STEP = 5'h03;
   localparam logic [26:0] WD_RESET_EXTRA = 27'h0000200;
endpackage

// ---- core/dtc_timer_block.sv ----
// Dual timer/counter, external interrupt detect and clock control registers
`timescale 1ns/1ps
`default_nettype none
module dtc_timer_block
   import dtc_pkg::*;
#(
   parameter int DIV_FAST_P = DIV_FAST,
   parameter int DIV_SLOW_P = DIV_SLOW
) (
   input wire logic sys_clk_in,
   input wire logic reset_n_in,
   input wire logic [7:0] sfr_addr_in,
   input wire logic sfr_direct_in,
   input wire logic sfr_bit_in,
   input wire logic sfr_wr_in,
   input wire logic sfr_rd_in,
   input wire logic [7:0] sfr_wdata_in,
   input wire logic first_timer_vector_ack_in,
   input wire logic second_timer_vector_ack_in,
   input wire logic ext_irq_a_vector_ack_in,
   input wire logic ext_irq_b_vector_ack_in,
   input wire logic idle_request_in,
   input wire logic power_down_request_in,
   input wire logic first_timer_count_pin_in,
   input wire logic second_timer_count_pin_in,
   input wire logic ext_irq_a_pin_in,
   input wire logic ext_irq_b_pin_in,
   output logic [7:0] sfr_rdata_out,
   output logic sfr_rvalid_out,
   output logic first_timer_overflow_flag_out,
   output logic second_timer_overflow_flag_out,
   output logic ext_irq_a_detect_flag_out,
   output logic ext_irq_b_detect_flag_out,
   output logic core_clk_en_out,
   output logic periph_clk_en_out,
   output logic [26:0] watchdog_irq_timeout_out,
   output logic [26:0] watchdog_reset_timeout_out
);

   generate
      if (DIV_FAST_P < 1 || DIV_SLOW_P < 2) begin : g_bad_range
         $error("dtc_timer_block: divider values below range");
      end
      if (DIV_SLOW_P > 16) begin : g_bad_width
         $error("dtc_timer_block: slow divider exceeds the 4-bit prescaler");
      end
      if (DIV_FAST_P >= 1 && (DIV_SLOW_P % DIV_FAST_P) != 0) begin : g_bad_ratio
         $error("dtc_timer_block: slow divider not a multiple of fast divider");
      end
   endgenerate

   // Pin vectors are ordered {irq_b, irq_a, count1, count0}
   typedef struct packed {
      logic [7:0] t0lo;
      logic [7:0] t0hi;
      logic [7:0] t1lo;
      logic [7:0] t1hi;
      logic [7:0] tctl;
      logic [7:0] tmode;
      logic [7:0] ckctl;
      logic [3:0] div;
      logic [3:0] sync1;
      logic [3:0] sync2;
      logic [3:0] prev;
      logic [7:0] rdata;
      logic rvalid;
      logic core_en;
      logic periph_en;
      logic [26:0] wd_irq;
      logic [26:0] wd_rst;
   } dtc_state_t;

   dtc_state_t s_r;
   dtc_state_t s_nxt;

   // One increment of a timer pair in modes 0-2; returns {overflow, high, low}
   function automatic logic [16:0] dtc_step(input logic [1:0] mode, input logic [7:0] hi,
                                            input logic [7:0] lo);
      logic [13:0] sum13;
      logic [16:0] sum16;
      logic [8:0] sum8;
      logic [16:0] res;
      sum13 = {1'b0, hi, lo[4:0]} + 14'h0001;
      sum16 = {1'b0, hi, lo} + 17'h00001;
      sum8 = {1'b0, lo} + 9'h001;
      case (mode)
         MODE_PRESCALED: begin
            res = {sum13[13], sum13[12:5], lo[7:5], sum13[4:0]};
         end
         MODE_FULL16: begin
            res = sum16;
         end
         MODE_RELOAD8: begin
            res = sum8[8] ? {1'b1, hi, hi} : {1'b0, hi, sum8[7:0]};
         end
         default: begin
            res = {1'b0, hi, lo};
         end
      endcase
      return res;
   endfunction

   logic [1:0] mode0;
   logic [1:0] mode1;
   logic gate0;
   logic gate1;
   logic ct0;
   logic ct1;
   logic [3:0] fall;
   logic tick_fast;
   logic tick_slow;
   logic frozen;
   logic tick0;
   logic tick1;
   logic en0;
   logic en1;
   logic inc0;
   logic inc1;
   logic inc0_hi;
   logic [16:0] step0;
   logic [16:0] step1;
   logic [8:0] lo0_sum;
   logic [8:0] hi0_sum;
   logic set_tf0;
   logic set_tf1;
   logic set_ie0;
   logic set_ie1;
   logic acc_ok;
   logic [7:0] bit_byte;
   logic [4:0] wd_exp;
   logic [26:0] wd_base;

   always_comb begin
      s_nxt = s_r;
      s_nxt.rvalid = 1'b0;

      // Two-stage synchronisers; edges are taken from the second stage only
      s_nxt.sync1 = {ext_irq_b_pin_in, ext_irq_a_pin_in,
                     second_timer_count_pin_in, first_timer_count_pin_in};
      s_nxt.sync2 = s_r.sync1;
      s_nxt.prev = s_r.sync2;
      fall = s_r.prev & ~s_r.sync2;

      s_nxt.core_en = ~(idle_request_in | power_down_request_in);
      s_nxt.periph_en = ~power_down_request_in;
      frozen = power_down_request_in;

      // Prescaler of the oscillator; stands still in power-down
      tick_slow = 1'b0;
      tick_fast = 1'b0;
      if (!frozen) begin
         tick_slow = (s_r.div == 4'(DIV_SLOW_P - 1));
         tick_fast = ((32'(s_r.div) % DIV_FAST_P) == (DIV_FAST_P - 1));
         s_nxt.div = tick_slow ? 4'h0 : s_r.div + 4'h1;
      end

      mode0 = s_r.tmode[TM_T0_LSB +: 2];
      mode1 = s_r.tmode[TM_T1_LSB +: 2];
      gate0 = s_r.tmode[TM_T0_LSB + TM_GATE];
      gate1 = s_r.tmode[TM_T1_LSB + TM_GATE];
      ct0 = s_r.tmode[TM_T0_LSB + TM_CT];
      ct1 = s_r.tmode[TM_T1_LSB + TM_CT];
      tick0 = s_r.ckctl[CK_T0M] ? tick_fast : tick_slow;
      tick1 = s_r.ckctl[CK_T1M] ? tick_fast : tick_slow;

      // Gate input is the external interrupt pin of the same timer
      en0 = s_r.tctl[TC_TR0] & (~gate0 | s_r.sync2[2]);
      // With timer 0 split, the run bit belongs to the high half of timer 0
      en1 = (mode0 == MODE_SPLIT | s_r.tctl[TC_TR1]) & (~gate1 | s_r.sync2[3]);
      inc0 = en0 & (ct0 ? (fall[0] & ~frozen) : tick0);
      inc1 = en1 & (ct1 ? (fall[1] & ~frozen) : tick1) & (mode1 != MODE_SPLIT);
      inc0_hi = s_r.tctl[TC_TR1] & tick1;

      set_tf0 = 1'b0;
      set_tf1 = 1'b0;
      step0 = dtc_step(mode0, s_r.t0hi, s_r.t0lo);
      step1 = dtc_step(mode1, s_r.t1hi, s_r.t1lo);
      lo0_sum = {1'b0, s_r.t0lo} + 9'h001;
      hi0_sum = {1'b0, s_r.t0hi} + 9'h001;

      if (mode0 == MODE_SPLIT) begin
         if (inc0) begin
            s_nxt.t0lo = lo0_sum[7:0];
            set_tf0 = lo0_sum[8];
         end
         if (inc0_hi) begin
            s_nxt.t0hi = hi0_sum[7:0];
            set_tf1 = hi0_sum[8];
         end
      end else if (inc0) begin
         {set_tf0, s_nxt.t0hi, s_nxt.t0lo} = step0;
      end

      if (inc1) begin
         s_nxt.t1hi = step1[15:8];
         s_nxt.t1lo = step1[7:0];
         // Timer 1 gives up its flag while timer 0 is split
         if (mode0 != MODE_SPLIT) begin
            set_tf1 = step1[16];
         end
      end

      // Falling edge when type is one, low level when zero
      set_ie0 = s_r.tctl[TC_IT0] & fall[2];
      set_ie1 = s_r.tctl[TC_IT1] & fall[3];

      // Register writes: a write to a counting byte wins over its increment
      acc_ok = sfr_direct_in & (sfr_addr_in >= SFR_BASE);
      bit_byte = {sfr_addr_in[7:3], 3'h0};
      if (sfr_wr_in && acc_ok) begin
         if (sfr_bit_in) begin
            if (bit_byte == ADDR_TCTL) begin
               s_nxt.tctl[sfr_addr_in[2:0]] = sfr_wdata_in[0];
            end
         end else begin
            case (sfr_addr_in)
               ADDR_TCTL: begin
                  s_nxt.tctl = sfr_wdata_in;
               end
               ADDR_TMODE: begin
                  s_nxt.tmode = sfr_wdata_in;
               end
               ADDR_T0LO: begin
                  s_nxt.t0lo = sfr_wdata_in;
               end
               ADDR_T1LO: begin
                  s_nxt.t1lo = sfr_wdata_in;
               end
               ADDR_T0HI: begin
                  s_nxt.t0hi = sfr_wdata_in;
               end
               ADDR_T1HI: begin
                  s_nxt.t1hi = sfr_wdata_in;
               end
               ADDR_CKCTL: begin
                  s_nxt.ckctl = sfr_wdata_in;
               end
               default: begin
               end
            endcase
         end
      end

      // Vector clears, then hardware sets so that a set in the same cycle wins
      if (first_timer_vector_ack_in) begin
         s_nxt.tctl[TC_TF0] = 1'b0;
      end
      if (second_timer_vector_ack_in) begin
         s_nxt.tctl[TC_TF1] = 1'b0;
      end
      if (ext_irq_a_vector_ack_in && s_r.tctl[TC_IT0]) begin
         s_nxt.tctl[TC_IE0] = 1'b0;
      end
      if (ext_irq_b_vector_ack_in && s_r.tctl[TC_IT1]) begin
         s_nxt.tctl[TC_IE1] = 1'b0;
      end
      if (set_tf0) begin
         s_nxt.tctl[TC_TF0] = 1'b1;
      end
      if (set_tf1) begin
         s_nxt.tctl[TC_TF1] = 1'b1;
      end
      // Level mode: flag mirrors the low pin, so software cannot hold it
      s_nxt.tctl[TC_IE0] = s_nxt.tctl[TC_IT0] ? (s_nxt.tctl[TC_IE0] | set_ie0)
                                              : ~s_r.sync2[2];
      s_nxt.tctl[TC_IE1] = s_nxt.tctl[TC_IT1] ? (s_nxt.tctl[TC_IE1] | set_ie1)
                                              : ~s_r.sync2[3];

      // Register reads, answered one cycle after the strobe
      if (sfr_rd_in && acc_ok) begin
         s_nxt.rvalid = 1'b1;
         if (sfr_bit_in) begin
            s_nxt.rdata = (bit_byte == ADDR_TCTL) ?
                          {UNIMPL_BITS, s_r.tctl[sfr_addr_in[2:0]]} : UNIMPL_READ;
         end else begin
            case (sfr_addr_in)
               ADDR_TCTL: begin
                  s_nxt.rdata = s_r.tctl;
               end
               ADDR_TMODE: begin
                  s_nxt.rdata = s_r.tmode;
               end
               ADDR_T0LO: begin
                  s_nxt.rdata = s_r.t0lo;
               end
               ADDR_T1LO: begin
                  s_nxt.rdata = s_r.t1lo;
               end
               ADDR_T0HI: begin
                  s_nxt.rdata = s_r.t0hi;
               end
               ADDR_T1HI: begin
                  s_nxt.rdata = s_r.t1hi;
               end
               ADDR_CKCTL: begin
                  s_nxt.rdata = s_r.ckctl;
               end
               default: s_nxt.rdata = UNIMPL_READ;
            endcase
         end
      end

      // Watchdog periods: exponent 17, 20, 23 or 26; the counter lives elsewhere
      wd_exp = WD_EXP0 + 5'(WD_EXP_STEP * s_r.ckctl[CK_WD_LSB +: 2]);
      wd_base = 27'h0000001 << wd_exp;
      s_nxt.wd_irq = wd_base;
      s_nxt.wd_rst = wd_base + WD_RESET_EXTRA;
   end

   always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         s_r.t0lo <= RST_COUNT;
         s_r.t0hi <= RST_COUNT;
         s_r.t1lo <= RST_COUNT;
         s_r.t1hi <= RST_COUNT;
         s_r.tctl <= RST_TCTL;
         s_r.tmode <= RST_TMODE;
         s_r.ckctl <= RST_CKCTL;
         s_r.div <= RST_DIV;
         s_r.sync1 <= RST_PINS;
         s_r.sync2 <= RST_PINS;
         s_r.prev <= RST_PINS;
         s_r.rdata <= RST_RDATA;
         s_r.rvalid <= 1'b0;
         s_r.core_en <= 1'b1;
         s_r.periph_en <= 1'b1;
         s_r.wd_irq <= RST_WD_IRQ;
         s_r.wd_rst <= RST_WD_RST;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign sfr_rdata_out = s_r.rdata;
   assign sfr_rvalid_out = s_r.rvalid;
   assign first_timer_overflow_flag_out = s_r.tctl[TC_TF0];
   assign second_timer_overflow_flag_out = s_r.tctl[TC_TF1];
   assign ext_irq_a_detect_flag_out = s_r.tctl[TC_IE0];
   assign ext_irq_b_detect_flag_out = s_r.tctl[TC_IE1];
   assign core_clk_en_out = s_r.core_en;
   assign periph_clk_en_out = s_r.periph_en;
   assign watchdog_irq_timeout_out = s_r.wd_irq;
   assign watchdog_reset_timeout_out = s_r.wd_rst;

endmodule
`default_nettype wire

// ---- tb/dtc_pin_model.sv ----
// Far-side model of the count, gate and interrupt pins
`timescale 1ns/1ps
`default_nettype none
module dtc_pin_model (
   input wire logic sys_clk_in,
   input wire logic [3:0] low_in,
   output logic [3:0] pin_out
);
   // Pins idle high and move just after an edge; callers hold each level two clocks or more
   initial pin_out = 4'hF;
   always @(posedge sys_clk_in) pin_out <= ~low_in;
endmodule
`default_nettype wire

// ---- tb/dtc_timer_chk.sv ----
// Assertions on the register port and clock-control outputs of the timer block
`timescale 1ns/1ps
`default_nettype none
module dtc_timer_chk (
   input wire logic sys_clk_in,
   input wire logic reset_n_in,
   input wire logic [7:0] sfr_addr_in,
   input wire logic sfr_direct_in,
   input wire logic sfr_bit_in,
   input wire logic sfr_wr_in,
   input wire logic sfr_rd_in,
   input wire logic [7:0] sfr_wdata_in,
   input wire logic idle_request_in,
   input wire logic power_down_request_in,
   input wire logic [7:0] sfr_rdata_out,
   input wire logic sfr_rvalid_out,
   input wire logic core_clk_en_out,
   input wire logic periph_clk_en_out,
   input wire logic [26:0] watchdog_irq_timeout_out,
   input wire logic [26:0] watchdog_reset_timeout_out
);
   default clocking @(posedge sys_clk_in);
   endclocking
   default disable iff (!reset_n_in);
   logic take;
   assign take = sfr_rd_in && sfr_direct_in && sfr_addr_in[7];
   read_answer_a: assert property (take |=> sfr_rvalid_out)
      else $error("read not answered");
   no_answer_a: assert property (!take |=> !sfr_rvalid_out)
      else $error("answer without a read");
   bit_other_a: assert property (take && sfr_bit_in && sfr_addr_in[7:3] != 5'h11
      |=> sfr_rdata_out == 8'hFF) else $error("bit read outside control byte");
   bit_ctl_a: assert property (take && sfr_bit_in && sfr_addr_in[7:3] == 5'h11
      |=> sfr_rdata_out[7:1] == 7'h7F) else $error("bit read upper bits");
   unimpl_a: assert property (take && !sfr_bit_in
      && (sfr_addr_in[7:3] != 5'h11 || sfr_addr_in[2:0] == 3'h7)
      |=> sfr_rdata_out == 8'hFF) else $error("unmapped read not all ones");
   wd_gap_a: assert property (watchdog_reset_timeout_out == watchdog_irq_timeout_out + 27'h200)
      else $error("watchdog reset gap");
   wd_select_a: assert property (sfr_wr_in && sfr_direct_in && !sfr_bit_in
      && sfr_addr_in == 8'h8E && sfr_wdata_in[7:6] == 2'h3
      |-> ##[1:3] watchdog_irq_timeout_out == 27'h4000000) else $error("watchdog period");
   idle_core_a: assert property (idle_request_in |=> !core_clk_en_out)
      else $error("core clock runs in idle");
   idle_periph_a: assert property (idle_request_in && !power_down_request_in
      |=> periph_clk_en_out) else $error("timer clock stopped in idle");
   pd_stop_a: assert property (power_down_request_in |=> !periph_clk_en_out && !core_clk_en_out)
      else $error("clocks run in power-down");
   cover property (take && sfr_bit_in);
   cover property (idle_request_in ##1 !core_clk_en_out);
   cover property (power_down_request_in ##1 !periph_clk_en_out);
endmodule
bind dtc_timer_block dtc_timer_chk u_dtc_timer_chk (.*);
`default_nettype wire

// ---- tb/tb_top.sv ----
// Self-checking testbench for the dual timer/counter block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   logic clk = 0, rst_n = 0, wr = 0, rd = 0, bm = 0, dir = 0, idle = 0, pd = 0;
   logic [7:0] addr = 0, dat = 0, rdata, r;
   logic [3:0] ack = 0, low = 0, pins;
   wire logic [3:0] flg;
   logic rvalid, cen, pen;
   logic [26:0] wdi, wdr;
   logic [7:0] q[$];
   int bad_count = 0, compares = 0, cyc = 0, n;
   always #20 clk = ~clk;
   dtc_pin_model u_dtc_pin_model (.sys_clk_in(clk), .low_in(low), .pin_out(pins));
   dtc_timer_block u_dtc_timer_block (
      .sys_clk_in(clk), .reset_n_in(rst_n), .sfr_addr_in(addr), .sfr_direct_in(dir),
      .sfr_bit_in(bm), .sfr_wr_in(wr), .sfr_rd_in(rd), .sfr_wdata_in(dat),
      .first_timer_vector_ack_in(ack[0]), .second_timer_vector_ack_in(ack[1]),
      .ext_irq_a_vector_ack_in(ack[2]), .ext_irq_b_vector_ack_in(ack[3]),
      .idle_request_in(idle), .power_down_request_in(pd),
      .first_timer_count_pin_in(pins[0]), .second_timer_count_pin_in(pins[1]),
      .ext_irq_a_pin_in(pins[2]), .ext_irq_b_pin_in(pins[3]),
      .sfr_rdata_out(rdata), .sfr_rvalid_out(rvalid),
      .first_timer_overflow_flag_out(flg[0]), .second_timer_overflow_flag_out(flg[1]),
      .ext_irq_a_detect_flag_out(flg[2]), .ext_irq_b_detect_flag_out(flg[3]),
      .core_clk_en_out(cen), .periph_clk_en_out(pen),
      .watchdog_irq_timeout_out(wdi), .watchdog_reset_timeout_out(wdr));
   task automatic cmp(input logic [26:0] g, input logic [26:0] e);
      compares++;
      if (g !== e) begin
         bad_count++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task automatic tick(input int k);
      repeat (k) @(posedge clk);
   endtask
   // Strobes drop one edge before the next request so no signal is driven twice per step
   task automatic acc(input logic w, input logic [7:0] a, d, input logic b, dr);
      wr <= w;
      rd <= !w;
      addr <= a;
      dat <= d;
      bm <= b;
      dir <= dr;
      tick(1);
      wr <= 0;
      rd <= 0;
      tick(1);
   endtask
   task automatic rdx(input logic [7:0] a, e, input logic b = 0);
      q.push_back(e);
      acc(0, a, 8'h00, b, 1);
   endtask
   task automatic wrx(input logic [7:0] a, d, input logic b = 0);
      acc(1, a, d, b, 1);
   endtask
   task automatic pulse(input int i);
      low[i] <= 1;
      tick(3);
      low[i] <= 0;
      tick(4);
   endtask
   task automatic kick(input int i);
      ack[i] <= 1;
      tick(1);
      ack[i] <= 0;
      tick(1);
   endtask
   task automatic test_done;
      if (q.size() != 0)
         bad_count++;
      $display("compares=%0d bad_count=%0d", compares, bad_count);
      if (bad_count == 0 && compares > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   // Reply watcher: every answer retires the oldest expectation
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         bad_count++;
         test_done;
      end else if (rvalid === 1'b1) begin
         if (q.size() == 0)
            cmp(rvalid, 0);
         else
            cmp(rdata, q.pop_front());
      end
   end
   initial begin
      r = 8'($urandom(8));
      tick(8);
      rst_n <= 1;
      tick(1);
      rdx(8'h88, 8'h00);
      for (int a = 8'h89; a < 8'h8E; a++)
         rdx(a[7:0], 8'h00);
      rdx(8'h8E, 8'h01);
      rdx(8'h8F, 8'hFF);
      rdx(8'h84, 8'hFF);
      rdx(8'h92, 8'hFF, 1);
      acc(0, 8'h8A, 8'h00, 0, 0);
      acc(0, 8'h7F, 8'h00, 0, 1);
      wrx(8'h8C, 8'h01, 1);
      rdx(8'h8C, 8'hFF, 1);
      rdx(8'h88, 8'h10);
      wrx(8'h89, r);
      rdx(8'h89, r);
      wrx(8'h88, 8'h00);
      $display("register map test done");
      wrx(8'h8E, 8'h19);
      for (int t = 0; t < 2; t++) begin
         for (int m = 0; m < 3; m++) begin
            r = 8'($urandom);
            wrx(8'h89, 8'(m << (4 * t)));
            wrx(8'(8'h8C + t), (m == 2) ? r : 8'hFF);
            wrx(8'(8'h8A + t), 8'hFF);
            wrx(8'h88, 8'(8'h10 << (2 * t)));
            n = 0;
            while (flg[t] !== 1'b1 && n < 60) begin
               tick(1);
               n++;
            end
            cmp(flg[t], 1);
            wrx(8'h88, 8'(8'h20 << (2 * t)));
            rdx(8'(8'h8A + t), (m == 2) ? r : ((m == 0) ? 8'hE0 : 8'h00));
            rdx(8'(8'h8C + t), (m == 2) ? r : 8'h00);
            kick(t);
            rdx(8'h88, 8'h00);
         end
      end
      $display("overflow test done");
      wrx(8'h8A, 8'h00);
      wrx(8'h89, 8'h05);
      wrx(8'h88, 8'h10);
      repeat (3) pulse(0);
      rdx(8'h8A, 8'h03);
      wrx(8'h89, 8'h0D);
      low[2] <= 1;
      tick(4);
      pulse(0);
      rdx(8'h8A, 8'h03);
      cmp(flg[2], 1);
      low[2] <= 0;
      tick(6);
      cmp(flg[2], 0);
      pulse(0);
      rdx(8'h8A, 8'h04);
      wrx(8'h88, 8'h11);
      pulse(2);
      cmp(flg[2], 1);
      kick(2);
      cmp(flg[2], 0);
      $display("pin test done");
      idle <= 1;
      tick(3);
      cmp({cen, pen}, 2'b01);
      pd <= 1;
      tick(3);
      cmp({cen, pen}, 2'b00);
      idle <= 0;
      pd <= 0;
      tick(3);
      $display("power test done");
      for (int w = 0; w < 4; w++) begin
         wrx(8'h8E, {w[1:0], 6'h19});
         tick(2);
         cmp(wdi, 27'h1 << (17 + 3 * w));
         cmp(wdr - wdi, 27'h200);
      end
      $display("watchdog test done");
      wrx(8'h88, 8'h00);
      wrx(8'h89, 8'h33);
      wrx(8'h8A, 8'hFE);
      wrx(8'h8C, 8'hFE);
      wrx(8'h8B, r);
      wrx(8'h88, 8'h50);
      n = 0;
      while (flg[1:0] !== 2'b11 && n < 60) begin
         tick(1);
         n++;
      end
      cmp(flg[1:0], 2'b11);
      wrx(8'h88, 8'hA0);
      rdx(8'h8A, 8'h00);
      rdx(8'h8C, 8'h00);
      rdx(8'h8B, r);
      wrx(8'h89, 8'h50);
      wrx(8'h8B, 8'h00);
      wrx(8'h88, 8'h44);
      repeat (2) pulse(1);
      rdx(8'h8B, 8'h02);
      pulse(3);
      cmp(flg[3], 1);
      kick(3);
      cmp(flg[3], 0);
      wrx(8'h88, 8'h00);
      low[3] <= 1;
      tick(6);
      cmp(flg[3], 1);
      low[3] <= 0;
      tick(6);
      cmp(flg[3], 0);
      $display("split and second pin test done");
      test_done;
   end
endmodule
`default_nettype wire
